// >>> verilog/wdog_pkg.sv
/*
  Shared constants and carrier types for the watchdog reset-source
  status and reload register block.
  Assumes an APB3 slave with 32-bit data, one register per word.
*/
package wdog_pkg;

  // Printed offsets are not word multiples: they are indices, byte = 4*idx
  localparam logic [11:0] IDX_RESET_SOURCE_CONTROL = 12'hff0;
  localparam logic [11:0] IDX_RELOAD_UPPER_BYTE = 12'hff1;
  localparam logic [11:0] IDX_RELOAD_HIGH_BYTE = 12'hff2;
  localparam logic [11:0] IDX_RELOAD_LOW_BYTE = 12'hff3;
  localparam int ADDR_W = 14;

  localparam int BIT_POR = 7;
  localparam int BIT_STOP = 6;
  localparam int BIT_WDT = 5;
  localparam int BIT_EXT = 4;
  localparam int BIT_SM = 0;

  localparam logic RST_SM = 1'b0;
  localparam logic [7:0] RST_RELOAD_BYTE = 8'hff;
  localparam logic [23:0] RST_COUNT = 24'hffffff;
  localparam logic [23:0] MIN_RELOAD = 24'h000004;

  // Reset and recovery causes, one pulse each
  typedef struct packed {
    logic power_on;
    logic ext_pin;
    logic wdt_run;
    logic debugger;
    logic debug_pin;
    logic stop_gpio;
    logic stop_wdt;
  } reset_cause_t;

  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_reset_flag;
  } flags_t;

endpackage

// >>> verilog/wdog_status_reload.sv
/*
  Watchdog reset-source flags, stop-mode configuration and 24-bit
  reload register set, reached over APB.
  Assumes cause inputs are synchronous pulses from the reset controller,
  the counter value comes from the timer on pclk, and stop_mode and the
  refresh strobe come from logic on the same clock.
*/
// Chosen here: register access over APB.
// Operation
// - The external-reset flag (bit 4) is set by an external pin reset.
// - That flag clears on power-on reset and on pin-change stop recovery.
// - Reading the control/status register clears the external flag.
// - Stop-mode bit 0 at 1 stops watchdog and oscillator in stop mode.
// - After an external pin reset only the external flag reads as set.
// - After a run-mode watchdog time-out only the watchdog flag is set.
// - Debugger reset or debug-pin wake leaves only the power-on flag.
// - A pin-change stop recovery leaves only the stop flag set.
// - A watchdog stop recovery sets both the stop and watchdog flags.
// - The refresh instruction loads the 24-bit reload into the counter.
// - Reload is upper byte 23:16, high byte 15:8, low byte 7:0.
// - Reload writes store a byte; reads return the live count byte.
// - The stop flag clears on power-on, run time-out and status read.
`timescale 1ns/1ps
`default_nettype none
module wdog_status_reload
  import wdog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire reset_cause_t cause,
  input wire logic refresh,
  input wire logic stop_mode,
  input wire logic [23:0] count_in,
  output logic [23:0] reload_value,
  output logic load_count,
  output logic wdt_run_en,
  output logic osc_run_en,
  output var flags_t flags
);

  localparam logic [ADDR_W-1:0] ADDR_CTL = {IDX_RESET_SOURCE_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_U = {IDX_RELOAD_UPPER_BYTE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_H = {IDX_RELOAD_HIGH_BYTE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_L = {IDX_RELOAD_LOW_BYTE, 2'b00};

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTL, SEL_U, SEL_H, SEL_L
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CTL: decode = SEL_CTL;
      ADDR_U: decode = SEL_U;
      ADDR_H: decode = SEL_H;
      ADDR_L: decode = SEL_L;
      default: decode = SEL_NONE;
    endcase
  endfunction

  typedef enum logic [2:0] {
    EV_NONE,
    EV_POR,
    EV_EXT,
    EV_WDT_RUN,
    EV_STOP_WDT,
    EV_STOP_GPIO
  } event_t;

  // One winner per cycle; power-on class causes outrank all others
  function automatic event_t pick_event(input reset_cause_t c);
    if (c.power_on || c.debugger || c.debug_pin) begin
      pick_event = EV_POR;
    end else if (c.ext_pin) begin
      pick_event = EV_EXT;
    end else if (c.wdt_run) begin
      pick_event = EV_WDT_RUN;
    end else if (c.stop_wdt) begin
      pick_event = EV_STOP_WDT;
    end else if (c.stop_gpio) begin
      pick_event = EV_STOP_GPIO;
    end else begin
      pick_event = EV_NONE;
    end
  endfunction

  // Flag image each event leaves behind; unnamed flags read as zero
  function automatic flags_t event_flags(input event_t ev);
    event_flags = '0;
    case (ev)
      EV_POR: begin
        event_flags.por = 1'b1;
      end
      EV_EXT: begin
        event_flags.external_reset_flag = 1'b1;
      end
      EV_WDT_RUN: begin
        event_flags.wdt = 1'b1;
      end
      EV_STOP_WDT: begin
        event_flags.stop = 1'b1;
        event_flags.wdt = 1'b1;
      end
      EV_STOP_GPIO: begin
        event_flags.stop = 1'b1;
      end
      default: begin
        event_flags = '0;
      end
    endcase
  endfunction

  function automatic logic [1:0] byte_index(input reg_sel_t s);
    case (s)
      SEL_U: byte_index = 2'h0;
      SEL_H: byte_index = 2'h1;
      SEL_L: byte_index = 2'h2;
      default: byte_index = 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] count_byte(
    input logic [23:0] c,
    input logic [1:0] i
  );
    case (i)
      2'h0: count_byte = c[23:16];
      2'h1: count_byte = c[15:8];
      2'h2: count_byte = c[7:0];
      default: count_byte = 8'h00;
    endcase
  endfunction

  // Reserved bits 3:1 always read as zero
  function automatic logic [7:0] ctl_image(input flags_t f, input logic sm);
    ctl_image = {f, 3'b000, sm};
  endfunction

  // Watchdog and oscillator share one stop condition
  function automatic logic run_allowed(input logic stop, input logic sm);
    run_allowed = ~(stop & sm);
  endfunction

  logic [7:0] reload_r [3];
  logic sm_r;

  logic por_r;
  logic stop_r;
  logic wdt_r;
  logic ext_r;

  logic access;
  logic setup;
  logic wr_en;
  logic rd_ctl;
  reg_sel_t sel;
  logic [1:0] byte_idx;

  event_t event_now;
  flags_t ev_flags;
  logic [7:0] rd_byte;
  logic [23:0] reload_nxt;

  // Zero-wait slave: the access phase completes in its first cycle
  assign access = psel & penable & clk_en;
  assign setup = psel & ~penable;
  assign sel = decode(paddr);
  assign byte_idx = byte_index(sel);
  assign wr_en = access & pwrite;
  assign rd_ctl = access & ~pwrite & (sel == SEL_CTL);
  assign event_now = pick_event(cause);
  assign ev_flags = event_flags(event_now);
  assign reload_nxt = {reload_r[0], reload_r[1], reload_r[2]};
  assign flags = '{por: por_r, stop: stop_r, wdt: wdt_r, external_reset_flag: ext_r};

  // Byte registers, index 0 upper, 1 high, 2 low
  for (genvar g = 0; g < 3; g++) begin : g_reload
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        reload_r[g] <= RST_RELOAD_BYTE;
      end else if (wr_en && byte_idx == 2'(g)) begin
        // No check on minimum value, software's duty
        reload_r[g] <= pwdata[7:0];
      end
    end
  end

  // Reserved bits 3:1 are not stored, so a nonzero write is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm_r <= RST_SM;
    end else if (wr_en && sel == SEL_CTL) begin
      sm_r <= pwdata[BIT_SM];
    end
  end

  // Power-on indicator; a status read leaves it standing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_r <= 1'b0;
    end else if (clk_en) begin
      if (event_now != EV_NONE) begin
        por_r <= ev_flags.por;
      end
    end
  end

  // Cause events outrank a read clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r <= 1'b0;
    end else if (clk_en) begin
      if (event_now != EV_NONE) begin
        stop_r <= ev_flags.stop;
      end else if (rd_ctl) begin
        stop_r <= 1'b0;
      end
    end
  end

  // Watchdog indicator; a status read leaves it standing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_r <= 1'b0;
    end else if (clk_en) begin
      if (event_now != EV_NONE) begin
        wdt_r <= ev_flags.wdt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_r <= 1'b0;
    end else if (clk_en) begin
      if (event_now != EV_NONE) begin
        ext_r <= ev_flags.external_reset_flag;
      end else if (rd_ctl) begin
        ext_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_count <= 1'b0;
    end else if (clk_en) begin
      load_count <= refresh;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value <= RST_COUNT;
    end else if (clk_en) begin
      reload_value <= reload_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_run_en <= 1'b1;
    end else if (clk_en) begin
      wdt_run_en <= run_allowed(stop_mode, sm_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_en <= 1'b1;
    end else if (clk_en) begin
      osc_run_en <= run_allowed(stop_mode, sm_r);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      SEL_CTL: begin
        rd_byte = ctl_image(flags, sm_r);
      end
      SEL_U, SEL_H, SEL_L: begin
        rd_byte = count_byte(count_in, byte_idx);
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is registered at the setup edge so it stands in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (clk_en) begin
      if (setup) begin
        prdata <= {24'h000000, rd_byte};
      end else begin
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (setup) begin
        pslverr <= (sel == SEL_NONE);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // pready drops for a cycle after the clock enable holds the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= clk_en;
    end
  end

endmodule
`default_nettype wire

// >>> sim/wdog_props.sv
/* Checker for wdog_status_reload; one clock, async reset. */
`timescale 1ns/1ps
`default_nettype none
module wdog_props import wdog_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire reset_cause_t cause,
  input wire logic refresh,
  input wire logic load_count,
  input wire flags_t flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property evt(logic [6:0] c, logic [3:0] f);
    clk_en && cause == c |=> flags == f;
  endproperty
  a_ext_only: assert property (evt(7'h20, 4'h1))
    else $error("ext flags");
  a_wdt_only: assert property (evt(7'h10, 4'h2))
    else $error("wdt flags");
  a_por_power: assert property (evt(7'h40, 4'h8))
    else $error("por flags");
  a_por_debug: assert property (evt(7'h08, 4'h8))
    else $error("debug flags");
  a_por_pin: assert property (evt(7'h04, 4'h8))
    else $error("pin flags");
  a_stop_pin: assert property (evt(7'h02, 4'h4))
    else $error("gpio flags");
  a_stop_wdt: assert property (evt(7'h01, 4'h6))
    else $error("stop wdt flags");
  a_load_now: assert property (clk_en && refresh |=> load_count)
    else $error("no load");
endmodule
bind wdog_status_reload wdog_props props_i (.*);
`default_nettype wire

// >>> sim/tb_top.sv
/* Bench for wdog_status_reload over APB; checker bound. */
`timescale 1ns/1ps
`default_nettype none
module tb_top import wdog_pkg::*; ;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, refresh = 0, stop_mode = 0, e, pready, pslverr;
  logic load_count, wdt_run_en, osc_run_en;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [23:0] count_in = 24'habcdef, reload_value;
  reset_cause_t cause = 0;
  flags_t flags;
  int n_errors = 0, cmp_count = 0;
  logic [11:0] rows [7] = '{12'h408, 12'h201, 12'h102, 12'h088, 12'h048,
    12'h024, 12'h016};
  always #4 pclk = ~pclk;
  wdog_status_reload dut (.*);
  task chk(input logic [31:0] s, x, input string n);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(negedge pclk);
  endtask
  task results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial #20000 begin
    n_errors++;
    results;
  end
  initial begin
    repeat (20) @(posedge pclk);
    {presetn, stop_mode} <= 2'h3;
    apb(1'h1, 14'h3fc0, 8'h01);
    foreach (rows[i]) begin
      @(posedge pclk);
      {cause, refresh} <= {rows[i][10:4], 1'h1};
      @(posedge pclk);
      {cause, refresh} <= 8'h0;
      @(negedge pclk);
      chk(flags, rows[i][3:0], "ev");
      chk(load_count, 1'h1, "load");
      apb(1'h0, 14'h3fc0, 8'h00);
      chk(q, {rows[i][3:0], 4'h1}, "ctl");
      chk(flags, rows[i][3:0] & 4'ha, "clr");
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, 14'h3fc4 + 14'(4 * i), 8'h12 + 8'(8'h22 * i));
      apb(1'h0, 14'h3fc4 + 14'(4 * i), 8'h00);
      chk(q, 8'hab + 8'(8'h22 * i), "count");
    end
    chk(reload_value, 24'h123456, "reload");
    chk({wdt_run_en, osc_run_en}, 2'h0, "run");
    @(posedge pclk);
    {clk_en, cause} <= {1'h0, 7'h20};
    @(posedge pclk);
    {clk_en, cause} <= {1'h1, 7'h00};
    @(negedge pclk);
    chk(flags, 4'h2, "hold");
    apb(1'h1, 14'h0100, 8'h00);
    chk(e, 1'h1, "err");
    @(posedge pclk);
    presetn <= 1'h0;
    @(negedge pclk);
    chk({reload_value, flags}, 28'hffffff0, "reset");
    @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk(pready, 1'h0, "rdy0");
    @(negedge pclk);
    chk(pready, 1'h1, "rdy1");
    apb(1'h0, 14'h3fc0, 8'h00);
    chk(q, 32'h0, "ctl0");
    results;
  end
endmodule
`default_nettype wire
